// File: hw/fault_pkg.sv
// package: fault classes, register map, field positions, reset values
// assumes: used by the fault escalation top and its testbench
package fault_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_HARD_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_MM_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_BUS_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_USAGE_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MM_ADDRESS   = 8'h10;
  localparam logic [7:0] ADDR_BUS_ADDRESS  = 8'h14;
  localparam logic [7:0] ADDR_PRIORITY     = 8'h18;
  localparam logic [7:0] ADDR_ENABLES      = 8'h1C;
  localparam logic [7:0] ADDR_STATE        = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // hard status
  localparam int HF_VECTOR_READ_ERROR_FLAG   = 0;
  localparam int HF_ESCALATED_FLAG = 1;
  // mem manage status
  localparam int MM_IACC   = 0;
  localparam int MM_DACC   = 1;
  localparam int MM_STK    = 2;
  localparam int MM_UNSTK  = 3;
  // bus status
  localparam int BF_STK    = 0;
  localparam int BF_UNSTK  = 1;
  localparam int BF_PREF   = 2;
  localparam int BF_PREC   = 3;
  localparam int BF_IMPR   = 4;
  // usage status
  localparam int UF_COPROCESSOR_ACCESS_FLAG   = 0;
  localparam int UF_UNDEFINED_INSTR_FLAG  = 1;
  localparam int UF_STATE  = 2;
  localparam int UF_RET    = 3;
  localparam int UF_UNAL   = 4;
  localparam int UF_ZERO_DIVISOR_FLAG   = 5;
  // priority config: 3 bytes, mm / bus / usage
  localparam int PRI_W     = 8;
  localparam int PRI_MM    = 0;
  localparam int PRI_BUS   = 8;
  localparam int PRI_USAGE = 16;
  // handler enables
  localparam int EN_MM     = 0;
  localparam int EN_BUS    = 1;
  localparam int EN_USAGE  = 2;
  // state register
  localparam int ST_LOCK   = 0;
  localparam int ST_NMI    = 1;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // fault class raised to the prioritiser
  typedef enum logic [2:0] {
    FC_NONE  = 3'b000,
    FC_HARD  = 3'b001,
    FC_MM    = 3'b010,
    FC_BUS   = 3'b011,
    FC_USAGE = 3'b100
  } fault_class_t;

  // lockup state
  typedef enum logic [1:0] {
    LK_RUN      = 2'b00,
    LK_LOCKED   = 2'b01,
    LK_LOCK_NMI = 2'b10
  } lock_state_t;

endpackage

// File: hw/fault_addr_capture.sv
// fault_addr_capture: latches a fault address once, until status clears
// assumes: load and clear are single-cycle pulses on CLOCK
`timescale 1ns/1ps
module fault_addr_capture (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // control
  input  wire logic        load,
  input  wire logic        clear,
  input  wire logic [31:0] addr_in,
  // result
  output logic      [31:0] addr_out,
  output logic             held
);

  typedef struct packed {
    logic [31:0] addr;
    logic        held;
  } cap_state_t;

  cap_state_t state_reg;
  cap_state_t state_next;

  // ----------------------------------------------------------------
  // first fault wins until software clears
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.held = 1'b0;
    end
    if (load && (!state_reg.held || clear)) begin
      state_next.addr = addr_in;
      state_next.held = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign addr_out = state_reg.addr;
  assign held     = state_reg.held;

  a_capture_load: assert property (@(posedge clk) disable iff (!arst_n)
    (load && !held) |=> (held && addr_out == $past(addr_in)))
    else $error("fault address not captured");

endmodule

// File: hw/fault_detect_escalation.sv
// file: top of the fault classification and escalation unit
// assumes: fault inputs are single-cycle pulses from logic on CLOCK
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module fault_detect_escalation (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  // axi4-lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // axi4-lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // axi4-lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // fetch, vector and data bus errors
  input  wire logic        FETCH_BUS_ERR,
  input  wire logic        VECTOR_BUS_ERR,
  input  wire logic        PRECISE_BUS_ERR,
  input  wire logic        IMPRECISE_BUS_ERR,
  input  wire logic        STACK_BUS_ERR,
  input  wire logic        UNSTACK_BUS_ERR,
  input  wire logic [31:0] BUS_FAULT_ADDR,
  // protection checker
  input  wire logic        NON_EXECUTABLE_REGION,
  input  wire logic        MPU_INSTR_VIOL,
  input  wire logic        MPU_DATA_VIOL,
  input  wire logic        MPU_STACK_VIOL,
  input  wire logic        MPU_UNSTACK_VIOL,
  input  wire logic [31:0] MM_FAULT_ADDR,
  // decode faults
  input  wire logic        COPROC_ACCESS,
  input  wire logic        UNDEFINED_INSTR,
  input  wire logic        LEAVE_COMPACT_SET,
  input  wire logic        BAD_CONTINUATION,
  input  wire logic        BAD_RETURN_VALUE,
  input  wire logic        UNALIGNED_ACCESS,
  input  wire logic        ZERO_DIVISOR,
  // executing context
  input  wire logic        IN_HANDLER,
  input  wire logic [7:0]  CURRENT_PRIORITY,
  input  wire logic [2:0]  ACTIVE_FAULT,
  input  wire logic        IN_NMI,
  input  wire logic        IN_HARD_FAULT,
  input  wire logic        BUS_HANDLER_ENTRY,
  input  wire logic        NMI_EVENT,
  input  wire logic        DEBUG_HALT,
  // to the prioritiser
  output logic             FAULT_VALID,
  output logic [2:0]       FAULT_CLASS,
  output logic             LOCKUP
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                hard;
    logic [3:0]                mm;
    logic [4:0]                bus;
    logic [5:0]                usage;
    logic [23:0]               pri;
    logic [2:0]                en;
    fault_pkg::lock_state_t    lock;
    logic                      fvalid;
    fault_pkg::fault_class_t   fclass;
    logic                      aw_held;
    logic [7:0]                aw_addr;
    logic                      w_held;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;

  logic [31:0] mm_addr;
  logic [31:0] bus_addr;
  logic        mm_held;
  logic        bus_held;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // escalation test for one configurable class
  function automatic logic escalates(input logic       en_bit,
                                     input logic [7:0] pri,
                                     input logic [2:0] cls);
    logic r;
    r = !en_bit;
    if (IN_HANDLER && pri >= CURRENT_PRIORITY) r = 1'b1;
    if (IN_HANDLER && ACTIVE_FAULT == cls) r = 1'b1;
    if (IN_NMI || IN_HARD_FAULT) r = 1'b1;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------
  logic       mm_hit;
  logic       bus_hit;
  logic       usage_hit;
  logic       mm_esc;
  logic       bus_esc;
  logic       usage_esc;
  logic       hard_hit;
  logic [3:0] mm_ev;
  logic [4:0] bus_ev;
  logic [5:0] usage_ev;

  always_comb begin
    mm_ev = '0;
    mm_ev[fault_pkg::MM_IACC]  = MPU_INSTR_VIOL || NON_EXECUTABLE_REGION;
    mm_ev[fault_pkg::MM_DACC]  = MPU_DATA_VIOL;
    mm_ev[fault_pkg::MM_STK]   = MPU_STACK_VIOL;
    mm_ev[fault_pkg::MM_UNSTK] = MPU_UNSTACK_VIOL;
    bus_ev = '0;
    bus_ev[fault_pkg::BF_STK]   = STACK_BUS_ERR;
    bus_ev[fault_pkg::BF_UNSTK] = UNSTACK_BUS_ERR;
    bus_ev[fault_pkg::BF_PREF]  = FETCH_BUS_ERR;
    bus_ev[fault_pkg::BF_PREC]  = PRECISE_BUS_ERR;
    bus_ev[fault_pkg::BF_IMPR]  = IMPRECISE_BUS_ERR;
    usage_ev = '0;
    usage_ev[fault_pkg::UF_COPROCESSOR_ACCESS_FLAG]  = COPROC_ACCESS;
    usage_ev[fault_pkg::UF_UNDEFINED_INSTR_FLAG] = UNDEFINED_INSTR;
    usage_ev[fault_pkg::UF_STATE] = LEAVE_COMPACT_SET || BAD_CONTINUATION;
    usage_ev[fault_pkg::UF_RET]   = BAD_RETURN_VALUE;
    usage_ev[fault_pkg::UF_UNAL]  = UNALIGNED_ACCESS;
    usage_ev[fault_pkg::UF_ZERO_DIVISOR_FLAG]  = ZERO_DIVISOR;
  end

  assign mm_hit    = |mm_ev;
  assign bus_hit   = |bus_ev;
  assign usage_hit = |usage_ev;
  assign mm_esc    = mm_hit && escalates(s_reg.en[fault_pkg::EN_MM],
                       s_reg.pri[fault_pkg::PRI_MM +: fault_pkg::PRI_W], 3'(fault_pkg::FC_MM));
  // stacking into the bus fault handler never escalates
  assign bus_esc   = bus_hit && !(BUS_HANDLER_ENTRY && STACK_BUS_ERR) &&
                     escalates(s_reg.en[fault_pkg::EN_BUS],
                       s_reg.pri[fault_pkg::PRI_BUS +: fault_pkg::PRI_W], 3'(fault_pkg::FC_BUS));
  assign usage_esc = usage_hit && escalates(s_reg.en[fault_pkg::EN_USAGE],
                       s_reg.pri[fault_pkg::PRI_USAGE +: fault_pkg::PRI_W],
                       3'(fault_pkg::FC_USAGE));
  assign hard_hit  = VECTOR_BUS_ERR || mm_esc || bus_esc || usage_esc;

  // ----------------------------------------------------------------
  // bus access decode
  // ----------------------------------------------------------------
  logic        do_write;
  logic        do_read;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [31:0] wr_old;
  logic        wr_ok;
  logic        clr_mm;
  logic        clr_bus;

  assign AWREADY  = !s_reg.aw_held;
  assign WREADY   = !s_reg.w_held;
  assign ARREADY  = !s_reg.rvalid;
  assign do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
  assign do_read  = ARVALID && !s_reg.rvalid;

  always_comb begin
    rd_word = fault_pkg::RESET_WORD;
    rd_ok   = 1'b1;
    unique case (ARADDR)
      fault_pkg::ADDR_HARD_STATUS:  rd_word = 32'(s_reg.hard);
      fault_pkg::ADDR_MM_STATUS:    rd_word = 32'(s_reg.mm);
      fault_pkg::ADDR_BUS_STATUS:   rd_word = 32'(s_reg.bus);
      fault_pkg::ADDR_USAGE_STATUS: rd_word = 32'(s_reg.usage);
      fault_pkg::ADDR_MM_ADDRESS:   rd_word = mm_addr;
      fault_pkg::ADDR_BUS_ADDRESS:  rd_word = bus_addr;
      fault_pkg::ADDR_PRIORITY:     rd_word = 32'(s_reg.pri);
      fault_pkg::ADDR_ENABLES:      rd_word = 32'(s_reg.en);
      fault_pkg::ADDR_STATE: begin
        rd_word[fault_pkg::ST_LOCK] = s_reg.lock != fault_pkg::LK_RUN;
        rd_word[fault_pkg::ST_NMI]  = s_reg.lock == fault_pkg::LK_LOCK_NMI;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    wr_old = fault_pkg::RESET_WORD;
    wr_ok  = 1'b1;
    unique case (s_reg.aw_addr)
      fault_pkg::ADDR_HARD_STATUS,
      fault_pkg::ADDR_MM_STATUS,
      fault_pkg::ADDR_BUS_STATUS,
      fault_pkg::ADDR_USAGE_STATUS: wr_old = fault_pkg::RESET_WORD;
      fault_pkg::ADDR_PRIORITY:     wr_old = 32'(s_reg.pri);
      fault_pkg::ADDR_ENABLES:      wr_old = 32'(s_reg.en);
      fault_pkg::ADDR_MM_ADDRESS,
      fault_pkg::ADDR_BUS_ADDRESS,
      fault_pkg::ADDR_STATE:        wr_old = fault_pkg::RESET_WORD;
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [31:0] wv;

  always_comb begin
    s_next  = s_reg;
    wv      = merge(wr_old, s_reg.w_data, s_reg.w_strb);
    clr_mm  = 1'b0;
    clr_bus = 1'b0;
    // write channel capture
    if (AWVALID && AWREADY) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      s_next.w_held = 1'b1;
      s_next.w_data = WDATA;
      s_next.w_strb = WSTRB;
    end
    // register writes; status bits are write-one-to-clear
    if (do_write) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = wr_ok ? fault_pkg::RESP_OKAY : fault_pkg::RESP_SLVERR;
      unique case (s_reg.aw_addr)
        fault_pkg::ADDR_HARD_STATUS:  s_next.hard  = s_reg.hard & ~wv[1:0];
        fault_pkg::ADDR_MM_STATUS: begin
          s_next.mm = s_reg.mm & ~wv[3:0];
          clr_mm    = |wv[3:0];
        end
        fault_pkg::ADDR_BUS_STATUS: begin
          s_next.bus = s_reg.bus & ~wv[4:0];
          clr_bus    = |wv[4:0];
        end
        fault_pkg::ADDR_USAGE_STATUS: s_next.usage = s_reg.usage & ~wv[5:0];
        fault_pkg::ADDR_PRIORITY:     s_next.pri   = wv[23:0];
        fault_pkg::ADDR_ENABLES:      s_next.en    = wv[2:0];
        default: ;
      endcase
    end
    if (s_reg.bvalid && BREADY) begin
      s_next.bvalid = 1'b0;
    end
    // read channel
    if (do_read) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rd_word;
      s_next.rresp  = rd_ok ? fault_pkg::RESP_OKAY : fault_pkg::RESP_SLVERR;
    end else if (s_reg.rvalid && RREADY) begin
      s_next.rvalid = 1'b0;
    end
    // sticky flags, set wins over clear
    s_next.mm    = s_next.mm | mm_ev;
    s_next.bus   = s_next.bus | bus_ev;
    s_next.usage = s_next.usage | usage_ev;
    if (VECTOR_BUS_ERR) s_next.hard[fault_pkg::HF_VECTOR_READ_ERROR_FLAG] = 1'b1;
    if (mm_esc || bus_esc || usage_esc) begin
      s_next.hard[fault_pkg::HF_ESCALATED_FLAG] = 1'b1;
    end
    // fault report to the prioritiser
    s_next.fvalid = (hard_hit || mm_hit || bus_hit || usage_hit) &&
                    s_reg.lock == fault_pkg::LK_RUN;
    if (hard_hit)       s_next.fclass = fault_pkg::FC_HARD;
    else if (mm_hit)    s_next.fclass = fault_pkg::FC_MM;
    else if (bus_hit)   s_next.fclass = fault_pkg::FC_BUS;
    else if (usage_hit) s_next.fclass = fault_pkg::FC_USAGE;
    else                s_next.fclass = fault_pkg::FC_NONE;
    // lockup
    unique case (s_reg.lock)
      fault_pkg::LK_RUN: begin
        if (hard_hit && IN_NMI) begin
          s_next.lock = fault_pkg::LK_LOCK_NMI;
        end else if (hard_hit && IN_HARD_FAULT) begin
          s_next.lock = fault_pkg::LK_LOCKED;
        end
      end
      fault_pkg::LK_LOCKED: begin
        if (NMI_EVENT || DEBUG_HALT) s_next.lock = fault_pkg::LK_RUN;
      end
      fault_pkg::LK_LOCK_NMI: begin
        if (DEBUG_HALT) s_next.lock = fault_pkg::LK_RUN;
      end
      default: s_next.lock = fault_pkg::LK_RUN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_reg      <= '0;
      s_reg.en   <= 3'h0;
      s_reg.lock <= fault_pkg::LK_RUN;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // address capture
  // ----------------------------------------------------------------
  fault_addr_capture u_mm_addr (
    .clk      (CLOCK),
    .arst_n   (ARST_N),
    .load     (mm_hit),
    .clear    (clr_mm),
    .addr_in  (MM_FAULT_ADDR),
    .addr_out (mm_addr),
    .held     (mm_held)
  );

  fault_addr_capture u_bus_addr (
    .clk      (CLOCK),
    .arst_n   (ARST_N),
    .load     (bus_hit && !IMPRECISE_BUS_ERR),
    .clear    (clr_bus),
    .addr_in  (BUS_FAULT_ADDR),
    .addr_out (bus_addr),
    .held     (bus_held)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign BVALID      = s_reg.bvalid;
  assign BRESP       = s_reg.bresp;
  assign RVALID      = s_reg.rvalid;
  assign RDATA       = s_reg.rdata;
  assign RRESP       = s_reg.rresp;
  assign FAULT_VALID = s_reg.fvalid;
  assign FAULT_CLASS = s_reg.fclass;
  assign LOCKUP      = s_reg.lock != fault_pkg::LK_RUN;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_vector_hard: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    VECTOR_BUS_ERR |=> s_reg.hard[fault_pkg::HF_VECTOR_READ_ERROR_FLAG])
    else $error("vector error did not set flag");

  a_disabled_escalate: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (usage_hit && !s_reg.en[fault_pkg::EN_USAGE]) |=> s_reg.hard[fault_pkg::HF_ESCALATED_FLAG])
    else $error("disabled handler fault not escalated");

  a_nonexec_flag: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    NON_EXECUTABLE_REGION |=> s_reg.mm[fault_pkg::MM_IACC])
    else $error("non executable access not flagged");

  a_precise_flag: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    PRECISE_BUS_ERR |=> s_reg.bus[fault_pkg::BF_PREC])
    else $error("precise bus error not flagged");

  a_div_flag: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ZERO_DIVISOR |=> s_reg.usage[fault_pkg::UF_ZERO_DIVISOR_FLAG])
    else $error("zero divisor not flagged");

  a_lock_enter: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (hard_hit && IN_HARD_FAULT && !LOCKUP) |=> LOCKUP)
    else $error("lockup not entered");

  a_nmi_no_exit: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (s_reg.lock == fault_pkg::LK_LOCK_NMI && !DEBUG_HALT) |=> LOCKUP)
    else $error("nmi lockup released without halt");

  a_lock_silent: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $past(LOCKUP) |-> !FAULT_VALID)
    else $error("fault reported during lockup");

  a_flag_sticky: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ($past(s_reg.usage[fault_pkg::UF_UNDEFINED_INSTR_FLAG]) && !$past(do_write))
      |-> s_reg.usage[fault_pkg::UF_UNDEFINED_INSTR_FLAG])
    else $error("usage flag lost without clear");

endmodule

// File: tb/fault_source.sv
// fault_source: far-side model of fetch, data bus and protection checker
// assumes: one fault pulse per fire request, address valid with the pulse
`timescale 1ns/1ps
module fault_source (
  // clock and request
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic [4:0]  sel,
  input  wire logic [31:0] addr,
  // fault pulses and address
  output logic      [17:0] pulses,
  output logic      [31:0] fault_addr
);
  initial fault_addr = 32'h0000_0000;
  // address only meaningful with its pulse, scrambled otherwise
  always @(posedge clk) begin
    pulses     <= fire ? 18'h00001 << sel : 18'h00000;
    fault_addr <= fire ? addr : ~fault_addr;
  end
endmodule

// File: tb/testbench.sv
// testbench: register bus tasks and fault scenarios for the escalation unit
// assumes: fault_source drives fault pulses, bench drives context levels
`timescale 1ns/1ps
module testbench;
  logic CLOCK = 1'b0, ARST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0, IN_HANDLER = 1'b0, IN_NMI = 1'b0, IN_HARD_FAULT = 1'b0;
  logic BUS_HANDLER_ENTRY = 1'b0, NMI_EVENT = 1'b0, DEBUG_HALT = 1'b0, fire = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, CURRENT_PRIORITY = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000, fa = 32'h0000_0000, rv, RDATA, BUS_FAULT_ADDR, MM_FAULT_ADDR;
  logic [3:0] WSTRB = 4'hF;
  logic [2:0] ACTIVE_FAULT = 3'h0, last_cls = 3'h0, FAULT_CLASS;
  logic [4:0] sel = 5'h00;
  logic [1:0] BRESP, RRESP, rsp;
  logic [17:0] pulses;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FAULT_VALID, LOCKUP;
  logic FETCH_BUS_ERR, VECTOR_BUS_ERR, PRECISE_BUS_ERR, IMPRECISE_BUS_ERR, STACK_BUS_ERR;
  logic UNSTACK_BUS_ERR, NON_EXECUTABLE_REGION, MPU_INSTR_VIOL, MPU_DATA_VIOL, MPU_STACK_VIOL;
  logic MPU_UNSTACK_VIOL, COPROC_ACCESS, UNDEFINED_INSTR, LEAVE_COMPACT_SET, BAD_CONTINUATION;
  logic BAD_RETURN_VALUE, UNALIGNED_ACCESS, ZERO_DIVISOR;
  // per pulse: status word index and flag bit
  logic [7:0] tbl [18] = '{8'h22, 8'h00, 8'h23, 8'h24, 8'h20, 8'h21, 8'h10, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h30, 8'h31, 8'h32, 8'h32, 8'h33, 8'h34, 8'h35};
  int miscompares = 0, compares = 0, cycles = 0;
  assign {ZERO_DIVISOR, UNALIGNED_ACCESS, BAD_RETURN_VALUE, BAD_CONTINUATION, LEAVE_COMPACT_SET,
    UNDEFINED_INSTR, COPROC_ACCESS, MPU_UNSTACK_VIOL, MPU_STACK_VIOL, MPU_DATA_VIOL,
    MPU_INSTR_VIOL, NON_EXECUTABLE_REGION, UNSTACK_BUS_ERR, STACK_BUS_ERR, IMPRECISE_BUS_ERR,
    PRECISE_BUS_ERR, VECTOR_BUS_ERR, FETCH_BUS_ERR} = pulses;
  assign MM_FAULT_ADDR = BUS_FAULT_ADDR;
  fault_detect_escalation fault_detect_escalation_i (.*);
  fault_source fault_source_i (.clk(CLOCK), .fire(fire), .sel(sel), .addr(fa),
    .pulses(pulses), .fault_addr(BUS_FAULT_ADDR));
  initial forever #4 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (FAULT_VALID) last_cls <= FAULT_CLASS;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] v);
    compares++;
    if (v !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BREADY && BVALID) BREADY <= 1'b0;
    end while (BREADY);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RREADY && RVALID) begin
        rv = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
      end
    end while (RREADY);
    cmp($sformatf("reg %h", a), e, rv);
  endtask
  task automatic pulse(input int s);
    last_cls = 3'h0;
    sel <= s[4:0];
    fa <= 32'hA000_0000 | s;
    fire <= 1'b1;
    @(posedge CLOCK);
    fire <= 1'b0;
    repeat (3) @(posedge CLOCK);
  endtask
  task automatic fault(input int s, input logic esc);
    pulse(s);
    cmp("class", esc ? 32'h1 : 32'(tbl[s][5:4]) + 32'h1, {29'h0, last_cls});
    chk({4'h0, tbl[s][5:4], 2'b00}, 32'h1 << tbl[s][3:0]);
    chk(8'h00, {30'h0, esc, s == 1});
    if (s == 2 || s == 8) chk(s == 2 ? 8'h14 : 8'h10, 32'hA000_0000 | s);
    for (int r = 0; r < 16; r += 4) wr(r[7:0], 32'hFFFF_FFFF);
  endtask
  task automatic ev(input logic nmi, input logic exp);
    NMI_EVENT <= nmi;
    DEBUG_HALT <= !nmi;
    @(posedge CLOCK);
    NMI_EVENT <= 1'b0;
    DEBUG_HALT <= 1'b0;
    repeat (2) @(posedge CLOCK);
    cmp("lockup", {31'h0, exp}, {31'h0, LOCKUP});
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    ARST_N <= 1'b1;
    @(posedge CLOCK);
    for (int r = 0; r <= 36; r += 4) chk(r[7:0], fault_pkg::RESET_WORD);
    cmp("resp", 32'h2, {30'h0, rsp});
    wr(8'h1C, 32'h7);
    for (int s = 0; s < 18; s++) fault(s, 1'b0);
    wr(8'h1C, 32'h0);
    fault(17, 1'b1);
    wr(8'h1C, 32'h7);
    wr(8'h18, 32'h0020_3005);
    IN_HANDLER <= 1'b1;
    CURRENT_PRIORITY <= 8'h10;
    fault(7, 1'b0);
    fault(12, 1'b1);
    ACTIVE_FAULT <= 3'h2;
    fault(10, 1'b1);
    ACTIVE_FAULT <= 3'h3;
    BUS_HANDLER_ENTRY <= 1'b1;
    fault(4, 1'b0);
    IN_HANDLER <= 1'b0;
    BUS_HANDLER_ENTRY <= 1'b0;
    ACTIVE_FAULT <= 3'h0;
    IN_HARD_FAULT <= 1'b1;
    pulse(1);
    chk(8'h20, 32'h1);
    pulse(17);
    cmp("class", 32'h0, {29'h0, last_cls});
    ev(1'b1, 1'b0);
    IN_HARD_FAULT <= 1'b0;
    IN_NMI <= 1'b1;
    pulse(1);
    chk(8'h20, 32'h3);
    ev(1'b1, 1'b1);
    ev(1'b0, 1'b0);
    test_done();
  end
endmodule
